// ===== pkg/tlic_pkg.sv
/*
 * Constants, register map and carrier types of the two-level interrupt
 * controller. Assumes a 32-bit APB register bus and one core clock.
 */
package tlic_pkg;

    // ------------------------------------------------------------------
    // Sizes and source numbering
    // ------------------------------------------------------------------
    localparam int NUM_SRC = 5;
    localparam int NUM_EXT = 2;
    localparam int ADDR_W  = 8;
    localparam int DATA_W  = 32;

    localparam logic [2:0] SRC_EXT_A  = 3'h0;
    localparam logic [2:0] SRC_TIMER0 = 3'h1;
    localparam logic [2:0] SRC_EXT_B  = 3'h2;
    localparam logic [2:0] SRC_TIMER1 = 3'h3;
    localparam logic [2:0] SRC_SERIAL = 3'h4;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFF_ENABLE = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_PRIO   = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_MODE   = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_PEND   = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_EVENT  = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_EMASK  = 8'h18;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int GLOBAL_EN_BIT = 7;
    localparam int PEND_TX_BIT   = 5;
    localparam int PEND_RX_BIT   = 6;
    localparam int STAT_VEC_LSB  = 2;
    localparam int STAT_REQ_BIT  = 5;
    localparam int STAT_LVL_BIT  = 6;

    localparam logic [NUM_SRC-1:0] SRC_RESET  = 5'h00;
    localparam logic [DATA_W-1:0]  DATA_RESET = 32'h0000_0000;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef logic [NUM_SRC-1:0] tlic_src_t;

    typedef struct packed {
        logic timer0Roll;
        logic timer1Roll;
        logic serTxDone;
        logic serRxDone;
    } tlic_periph_s;

    typedef struct packed {
        logic       valid;
        logic       level;
        logic [2:0] vector;
    } tlic_cpu_req_s;

    typedef enum logic [1:0] {
        SVC_NONE   = 2'b00,
        SVC_LOW    = 2'b01,
        SVC_NESTED = 2'b11,
        SVC_HIGH   = 2'b10
    } tlic_svc_e;

endpackage

// ===== rtl/tlic_ext_sense.sv
/*
 * Sense logic of one external request pin: synchroniser, falling-edge
 * detector and sticky flag. Assumes the pin is asynchronous to core_clk.
 */
`timescale 1ns/1ps
module tlic_ext_sense (
    input  wire logic core_clk,
    input  wire logic srst,
    input  wire logic pinIn,
    input  wire logic edgeMode,
    input  wire logic clearFlag,
    output logic      requestFlag
);
    logic syncFirst;
    logic syncSecond;
    logic pinPrev;
    logic edgeFlag;

    always_ff @(posedge core_clk) begin
        if (srst) begin
            syncFirst  <= 1'b1;
            syncSecond <= 1'b1;
            pinPrev    <= 1'b1;
        end else begin
            syncFirst  <= pinIn;
            syncSecond <= syncFirst;
            pinPrev    <= syncSecond;
        end
    end

    // A new falling edge wins over a clear in the same cycle.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            edgeFlag <= 1'b0;
        end else begin
            edgeFlag <= (edgeMode & pinPrev & ~syncSecond)
                      | (edgeFlag & edgeMode & ~clearFlag);
        end
    end

    assign requestFlag = edgeMode ? edgeFlag : ~syncSecond;
endmodule

// ===== rtl/tlic_arbiter.sv
/*
 * Fixed-order selection of the winning request at each priority level.
 * Assumes all inputs are registered state of the same clock.
 */
`timescale 1ns/1ps
module tlic_arbiter (
    input  wire tlic_pkg::tlic_src_t pending,
    input  wire tlic_pkg::tlic_src_t enable,
    input  wire tlic_pkg::tlic_src_t highSel,
    input  wire logic                globalEn,
    output logic                     hiValid,
    output logic [2:0]               hiIndex,
    output logic                     loValid,
    output logic [2:0]               loIndex
);
    tlic_pkg::tlic_src_t live;

    assign live = pending & enable & {tlic_pkg::NUM_SRC{globalEn}};

    // Lower source number wins within a level.
    always_comb begin
        hiValid = 1'b0;
        hiIndex = 3'h0;
        loValid = 1'b0;
        loIndex = 3'h0;
        for (int i = tlic_pkg::NUM_SRC - 1; i >= 0; i--) begin
            if (live[i] && highSel[i]) begin
                hiValid = 1'b1;
                hiIndex = 3'(i);
            end
            if (live[i] && !highSel[i]) begin
                loValid = 1'b1;
                loIndex = 3'(i);
            end
        end
    end
endmodule

// ===== rtl/tlic_top.sv
/*
 * Two-level interrupt controller: five request sources, per-source
 * enable, priority, pending flag and vector, a global enable, nesting
 * of one high-level routine over a low-level one, and an APB slave.
 * Assumes peripheral pulses come from core_clk logic and the CPU control
 * unit acknowledges a presented request and signals routine return.
 */
// The register offsets and register access over APB are this design's own decisions.
`timescale 1ns/1ps
module tlic_top (
    input  wire logic                   core_clk,
    input  wire logic                   srst,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [7:0]             paddr,
    input  wire logic [31:0]            pwdata,
    output logic [31:0]                 prdata,
    output logic                        pready,
    output logic                        pslverr,
    input  wire logic                   extIrqLineA,
    input  wire logic                   extIrqLineB,
    input  wire tlic_pkg::tlic_periph_s periph,
    input  wire logic                   cpuAck,
    input  wire logic                   cpuReturn,
    output tlic_pkg::tlic_cpu_req_s     cpuReq,
    output logic                        irq
);
    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    tlic_pkg::tlic_src_t     enable_reg;
    tlic_pkg::tlic_src_t     prio_reg;
    tlic_pkg::tlic_src_t     eventMask_reg;
    tlic_pkg::tlic_src_t     event_reg;
    tlic_pkg::tlic_src_t     pendPrev_reg;
    tlic_pkg::tlic_src_t     pendVec;
    tlic_pkg::tlic_cpu_req_s cpuReq_next;
    tlic_pkg::tlic_svc_e     svc_reg;
    tlic_pkg::tlic_svc_e     svc_next;
    logic                    globalEn_reg;
    logic [1:0]              edgeMode_reg;
    logic                    timer0Pend_reg;
    logic                    timer1Pend_reg;
    logic                    txDone_reg;
    logic                    rxDone_reg;
    logic [1:0]              extPins;
    logic [1:0]              extFlag;
    logic [1:0]              extClear;
    logic                    accessFirst;
    logic                    wrDone;
    logic                    rdDone;
    logic                    addrHit;
    logic [31:0]             readData;
    logic                    wrPend;
    logic                    ackTake;
    logic                    hiValid;
    logic [2:0]              hiIndex;
    logic                    loValid;
    logic [2:0]              loIndex;

    // ------------------------------------------------------------------
    // APB handshake
    // ------------------------------------------------------------------
    // Every access phase lasts two cycles: read data is captured in the
    // first and pready is raised for the second, where writes land.
    assign accessFirst = psel & penable & ~pready;
    assign wrDone      = psel & penable & pready & pwrite;
    assign rdDone      = psel & penable & pready & ~pwrite;
    assign wrPend      = wrDone & (paddr == tlic_pkg::OFF_PEND);

    always_comb begin
        addrHit = 1'b1;
        unique case (paddr)
            tlic_pkg::OFF_ENABLE,
            tlic_pkg::OFF_PRIO,
            tlic_pkg::OFF_MODE,
            tlic_pkg::OFF_PEND,
            tlic_pkg::OFF_STATUS,
            tlic_pkg::OFF_EVENT,
            tlic_pkg::OFF_EMASK: addrHit = 1'b1;
            default:             addrHit = 1'b0;
        endcase
    end

    always_comb begin
        readData = tlic_pkg::DATA_RESET;
        unique case (paddr)
            tlic_pkg::OFF_ENABLE: begin
                readData[tlic_pkg::NUM_SRC-1:0]    = enable_reg;
                readData[tlic_pkg::GLOBAL_EN_BIT]  = globalEn_reg;
            end
            tlic_pkg::OFF_PRIO: begin
                readData[tlic_pkg::NUM_SRC-1:0] = prio_reg;
            end
            tlic_pkg::OFF_MODE: begin
                readData[tlic_pkg::NUM_EXT-1:0] = edgeMode_reg;
            end
            tlic_pkg::OFF_PEND: begin
                readData[tlic_pkg::NUM_SRC-1:0]  = pendVec;
                readData[tlic_pkg::PEND_TX_BIT]  = txDone_reg;
                readData[tlic_pkg::PEND_RX_BIT]  = rxDone_reg;
            end
            tlic_pkg::OFF_STATUS: begin
                readData[1:0] = svc_reg;
                readData[tlic_pkg::STAT_VEC_LSB +: 3] = cpuReq.vector;
                readData[tlic_pkg::STAT_REQ_BIT] = cpuReq.valid;
                readData[tlic_pkg::STAT_LVL_BIT] = cpuReq.level;
            end
            tlic_pkg::OFF_EVENT: begin
                readData[tlic_pkg::NUM_SRC-1:0] = event_reg;
            end
            tlic_pkg::OFF_EMASK: begin
                readData[tlic_pkg::NUM_SRC-1:0] = eventMask_reg;
            end
            default: readData = tlic_pkg::DATA_RESET;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= tlic_pkg::DATA_RESET;
        end else begin
            pready  <= accessFirst;
            pslverr <= accessFirst & ~addrHit;
            if (accessFirst && !pwrite) begin
                prdata <= readData;
            end
        end
    end

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (srst) begin
            enable_reg    <= tlic_pkg::SRC_RESET;
            globalEn_reg  <= 1'b0;
            prio_reg      <= tlic_pkg::SRC_RESET;
            edgeMode_reg  <= 2'h0;
            eventMask_reg <= tlic_pkg::SRC_RESET;
        end else if (wrDone) begin
            unique case (paddr)
                tlic_pkg::OFF_ENABLE: begin
                    enable_reg   <= pwdata[tlic_pkg::NUM_SRC-1:0];
                    globalEn_reg <= pwdata[tlic_pkg::GLOBAL_EN_BIT];
                end
                tlic_pkg::OFF_PRIO: begin
                    prio_reg <= pwdata[tlic_pkg::NUM_SRC-1:0];
                end
                tlic_pkg::OFF_MODE: begin
                    edgeMode_reg <= pwdata[tlic_pkg::NUM_EXT-1:0];
                end
                tlic_pkg::OFF_EMASK: begin
                    eventMask_reg <= pwdata[tlic_pkg::NUM_SRC-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // External sources
    // ------------------------------------------------------------------
    assign extPins = {extIrqLineB, extIrqLineA};
    assign ackTake = cpuAck & cpuReq.valid;

    assign extClear[0] = (wrPend & pwdata[tlic_pkg::SRC_EXT_A])
                       | (ackTake & (cpuReq.vector == tlic_pkg::SRC_EXT_A));
    assign extClear[1] = (wrPend & pwdata[tlic_pkg::SRC_EXT_B])
                       | (ackTake & (cpuReq.vector == tlic_pkg::SRC_EXT_B));

    for (genvar g = 0; g < tlic_pkg::NUM_EXT; g++) begin : gExt
        tlic_ext_sense uSense (
            .core_clk    (core_clk),
            .srst        (srst),
            .pinIn       (extPins[g]),
            .edgeMode    (edgeMode_reg[g]),
            .clearFlag   (extClear[g]),
            .requestFlag (extFlag[g])
        );
    end

    // ------------------------------------------------------------------
    // On-chip sources
    // ------------------------------------------------------------------
    // A timer flag clears when its request is taken; serial flags are
    // cleared by software only, since the routine must tell them apart.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            timer0Pend_reg <= 1'b0;
            timer1Pend_reg <= 1'b0;
        end else begin
            timer0Pend_reg <= periph.timer0Roll
                | (timer0Pend_reg
                   & ~(wrPend & pwdata[tlic_pkg::SRC_TIMER0])
                   & ~(ackTake
                       & (cpuReq.vector == tlic_pkg::SRC_TIMER0)));
            timer1Pend_reg <= periph.timer1Roll
                | (timer1Pend_reg
                   & ~(wrPend & pwdata[tlic_pkg::SRC_TIMER1])
                   & ~(ackTake
                       & (cpuReq.vector == tlic_pkg::SRC_TIMER1)));
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            txDone_reg <= 1'b0;
            rxDone_reg <= 1'b0;
        end else begin
            txDone_reg <= periph.serTxDone
                | (txDone_reg & ~(wrPend & pwdata[tlic_pkg::PEND_TX_BIT]));
            rxDone_reg <= periph.serRxDone
                | (rxDone_reg & ~(wrPend & pwdata[tlic_pkg::PEND_RX_BIT]));
        end
    end

    // Two pins and three on-chip units make up the source vector.
    always_comb begin
        pendVec                       = tlic_pkg::SRC_RESET;
        pendVec[tlic_pkg::SRC_EXT_A]  = extFlag[0];
        pendVec[tlic_pkg::SRC_EXT_B]  = extFlag[1];
        pendVec[tlic_pkg::SRC_TIMER0] = timer0Pend_reg;
        pendVec[tlic_pkg::SRC_TIMER1] = timer1Pend_reg;
        pendVec[tlic_pkg::SRC_SERIAL] = txDone_reg | rxDone_reg;
    end

    // ------------------------------------------------------------------
    // Arbitration and nesting
    // ------------------------------------------------------------------
    tlic_arbiter uArb (
        .pending  (pendVec),
        .enable   (enable_reg),
        .highSel  (prio_reg),
        .globalEn (globalEn_reg),
        .hiValid  (hiValid),
        .hiIndex  (hiIndex),
        .loValid  (loValid),
        .loIndex  (loIndex)
    );

    // The request is withheld for the cycle after an acknowledge so the
    // CPU never sees a stale vector.
    always_comb begin
        cpuReq_next = '0;
        if (!ackTake) begin
            if (hiValid && svc_reg != tlic_pkg::SVC_HIGH
                    && svc_reg != tlic_pkg::SVC_NESTED) begin
                cpuReq_next.valid  = 1'b1;
                cpuReq_next.level  = 1'b1;
                cpuReq_next.vector = hiIndex;
            end else if (loValid && svc_reg == tlic_pkg::SVC_NONE) begin
                cpuReq_next.valid  = 1'b1;
                cpuReq_next.level  = 1'b0;
                cpuReq_next.vector = loIndex;
            end
        end
    end

    always_comb begin
        svc_next = svc_reg;
        if (ackTake) begin
            unique case (svc_reg)
                tlic_pkg::SVC_NONE:   svc_next = cpuReq.level
                                               ? tlic_pkg::SVC_HIGH
                                               : tlic_pkg::SVC_LOW;
                tlic_pkg::SVC_LOW:    svc_next = tlic_pkg::SVC_NESTED;
                tlic_pkg::SVC_NESTED: svc_next = tlic_pkg::SVC_NESTED;
                tlic_pkg::SVC_HIGH:   svc_next = tlic_pkg::SVC_HIGH;
            endcase
        end else if (cpuReturn) begin
            unique case (svc_reg)
                tlic_pkg::SVC_NONE:   svc_next = tlic_pkg::SVC_NONE;
                tlic_pkg::SVC_LOW:    svc_next = tlic_pkg::SVC_NONE;
                tlic_pkg::SVC_NESTED: svc_next = tlic_pkg::SVC_LOW;
                tlic_pkg::SVC_HIGH:   svc_next = tlic_pkg::SVC_NONE;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            svc_reg <= tlic_pkg::SVC_NONE;
            cpuReq  <= '0;
        end else begin
            svc_reg <= svc_next;
            cpuReq  <= cpuReq_next;
        end
    end

    // ------------------------------------------------------------------
    // Event status and interrupt line
    // ------------------------------------------------------------------
    // A new request sets its bit; a read of the event register clears,
    // but a bit set in the same cycle survives.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            pendPrev_reg <= tlic_pkg::SRC_RESET;
            event_reg    <= tlic_pkg::SRC_RESET;
            irq          <= 1'b0;
        end else begin
            pendPrev_reg <= pendVec;
            event_reg    <= (pendVec & ~pendPrev_reg)
                | (event_reg
                   & ~{tlic_pkg::NUM_SRC{rdDone
                       & (paddr == tlic_pkg::OFF_EVENT)}});
            irq <= |(event_reg & eventMask_reg);
        end
    end
endmodule

// ===== testbench/tlic_monitor.sv
/* Checker of the controller ports.
   Assumes it is bound to tlic_top. */
`timescale 1ns/1ps
module tlic_monitor (
    input wire logic                    core_clk,
    input wire logic                    srst,
    input wire logic                    psel,
    input wire logic                    penable,
    input wire logic                    pwrite,
    input wire logic [7:0]              paddr,
    input wire logic [31:0]             pwdata,
    input wire logic [31:0]             prdata,
    input wire logic                    pready,
    input wire logic                    pslverr,
    input wire logic                    cpuAck,
    input wire logic                    cpuReturn,
    input wire tlic_pkg::tlic_cpu_req_s cpuReq,
    input wire logic                    irq
);
    logic gEn;
    logic loBusy;
    logic hiBusy;
    logic taken;

    assign taken = cpuAck && cpuReq.valid;

    // Global enable shadow.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            gEn <= 1'b0;
        end else if (psel && penable && pready && pwrite && !pslverr
                     && paddr == tlic_pkg::OFF_ENABLE) begin
            gEn <= pwdata[tlic_pkg::GLOBAL_EN_BIT];
        end
    end

    // Routines in service; a return pops high first.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            loBusy <= 1'b0;
            hiBusy <= 1'b0;
        end else if (taken) begin
            hiBusy <= hiBusy | cpuReq.level;
            loBusy <= loBusy | !cpuReq.level;
        end else if (cpuReturn) begin
            hiBusy <= 1'b0;
            loBusy <= loBusy & hiBusy;
        end
    end

    // ------
    // Assertions
    // ------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);
    sequence setup_s; psel && !penable; endsequence
    sequence g_off_s; !gEn ##1 !gEn; endsequence

    a_reset_quiet: assert property (
        $fell(srst) |-> cpuReq == 5'h00 && !irq && !pready)
        else $error("busy after reset");
    a_apb_wait: assert property (
        setup_s |=> !pready ##1 pready)
        else $error("ready timing");
    a_ready_pulse: assert property (
        pready |=> !pready) else $error("ready held");
    a_bad_addr: assert property (
        pready |-> pslverr == (paddr > 8'h18 || paddr[1:0] != 2'h0))
        else $error("error flag");
    a_bad_read: assert property (
        pready && pslverr && !pwrite |-> prdata == 32'h0000_0000)
        else $error("bad read data");
    a_global_gate: assert property (
        g_off_s |-> !cpuReq.valid) else $error("request while gated");
    a_take_drops: assert property (
        taken |=> !cpuReq.valid) else $error("held after ack");
    a_low_waits: assert property (
        loBusy || hiBusy |-> !(cpuReq.valid && !cpuReq.level))
        else $error("low request while in service");
    a_high_waits: assert property (
        hiBusy |-> !cpuReq.valid) else $error("high busy");
    a_vec_range: assert property (
        cpuReq.valid |-> cpuReq.vector < 3'h5)
        else $error("vector out of range");
endmodule

bind tlic_top tlic_monitor mon (
    .core_clk  (core_clk),
    .srst      (srst),
    .psel      (psel),
    .penable   (penable),
    .pwrite    (pwrite),
    .paddr     (paddr),
    .pwdata    (pwdata),
    .prdata    (prdata),
    .pready    (pready),
    .pslverr   (pslverr),
    .cpuAck    (cpuAck),
    .cpuReturn (cpuReturn),
    .cpuReq    (cpuReq),
    .irq       (irq)
);

// ===== testbench/tlic_cpu_model.sv
/* CPU, timer and serial model.
   Assumes calls just after a rising edge. */
`timescale 1ns/1ps
module tlic_cpu_model (
    input  wire logic                    core_clk,
    input  wire logic                    srst,
    input  wire tlic_pkg::tlic_cpu_req_s cpuReq,
    input  wire logic [3:0]              ackWait,
    output tlic_pkg::tlic_periph_s       periph,
    output logic                         cpuAck,
    output logic                         cpuReturn
);
    logic [3:0] waitCnt;

    initial begin
        periph    = 4'h0;
        cpuAck    = 1'b0;
        cpuReturn = 1'b0;
        waitCnt   = 4'h0;
    end

    // Ack pulse after ackWait cycles.
    always @(posedge core_clk) begin
        if (srst || cpuAck || !cpuReq.valid) begin
            cpuAck  <= 1'b0;
            waitCnt <= 4'h0;
        end else if (waitCnt == ackWait) begin
            cpuAck  <= 1'b1;
        end else begin
            waitCnt <= waitCnt + 4'h1;
        end
    end

    task automatic fire(input tlic_pkg::tlic_periph_s p);
        periph <= p;
        @(posedge core_clk);
        periph <= 4'h0;
    endtask

    task automatic ret();
        cpuReturn <= 1'b1;
        @(posedge core_clk);
        cpuReturn <= 1'b0;
    endtask
endmodule

// ===== testbench/tlic_bench.sv
/* Self-checking controller bench.
   Assumes the CPU model acknowledges. */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
    miscompares++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module tlic_bench;
    logic        core_clk    = 1'b0;
    logic        srst        = 1'b1;
    logic        psel        = 1'b0;
    logic        penable     = 1'b0;
    logic        pwrite      = 1'b0;
    logic [7:0]  paddr       = 8'h00;
    logic [31:0] pwdata      = 32'h0000_0000;
    logic        extIrqLineA = 1'b1;
    logic        extIrqLineB = 1'b1;
    logic [3:0]  ackWait     = 4'h0;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic        pready;
    logic        pslverr;
    logic        err;
    logic        seen;
    logic        cpuAck;
    logic        cpuReturn;
    logic        irq;
    int          miscompares = 0;
    int          n_checks    = 0;
    tlic_pkg::tlic_periph_s  periph;
    tlic_pkg::tlic_cpu_req_s cpuReq;

    typedef struct {
        logic [7:0]  a;
        logic [31:0] q;
        logic        e;
    } tlic_row_s;
    tlic_row_s rows [6] = '{
        '{8'h00, 32'h0000_009F, 1'b0},
        '{8'h04, 32'h0000_001F, 1'b0},
        '{8'h08, 32'h0000_0003, 1'b0},
        '{8'h18, 32'h0000_001F, 1'b0},
        '{8'h10, 32'h0000_0000, 1'b0},
        '{8'h1C, 32'h0000_0000, 1'b1}};

    tlic_top uut (
        .core_clk    (core_clk),
        .srst        (srst),
        .psel        (psel),
        .penable     (penable),
        .pwrite      (pwrite),
        .paddr       (paddr),
        .pwdata      (pwdata),
        .prdata      (prdata),
        .pready      (pready),
        .pslverr     (pslverr),
        .extIrqLineA (extIrqLineA),
        .extIrqLineB (extIrqLineB),
        .periph      (periph),
        .cpuAck      (cpuAck),
        .cpuReturn   (cpuReturn),
        .cpuReq      (cpuReq),
        .irq         (irq)
    );
    tlic_cpu_model cpu (
        .core_clk  (core_clk),
        .srst      (srst),
        .cpuReq    (cpuReq),
        .ackWait   (ackWait),
        .periph    (periph),
        .cpuAck    (cpuAck),
        .cpuReturn (cpuReturn)
    );

    always #20 core_clk = ~core_clk;

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic bound(input int k, input int lim);
        if (k >= lim) begin
            miscompares++;
            $display("unexpected wait exp %0d got %0d", lim, k);
            report_and_stop();
        end
    endtask

    // One APB transfer; data taken at the ready edge.
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge core_clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        bound(k, 20);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic take(input logic [2:0] v, input logic l);
        int k;
        k = 0;
        do begin
            @(posedge core_clk);
            k++;
        end while (cpuAck !== 1'b1 && k < 60);
        bound(k, 60);
        `CHK("valid", 1'b1, cpuReq.valid);
        `CHK("vector", v, cpuReq.vector);
        `CHK("level", l, cpuReq.level);
    endtask

    task automatic quiet(input int n);
        seen = 1'b0;
        repeat (n) begin
            @(posedge core_clk);
            if (cpuReq.valid !== 1'b0) begin
                seen = 1'b1;
            end
        end
    endtask

    initial begin
        repeat (10) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        foreach (rows[i]) begin
            apb(1'b1, rows[i].a, 32'hFFFF_FFFF);
            `CHK("write error", rows[i].e, err);
            apb(1'b0, rows[i].a, 32'h0000_0000);
            `CHK("readback", rows[i].q, rd);
        end
        srst <= 1'b1;
        repeat (10) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        foreach (rows[i]) begin
            apb(1'b0, rows[i].a, 32'h0000_0000);
            `CHK("reset value", 32'h0000_0000, rd);
        end
        apb(1'b1, 8'h00, 32'h0000_001F);
        apb(1'b1, 8'h18, 32'h0000_0002);
        cpu.fire(4'h8);
        quiet(6);
        `CHK("gated request", 1'b0, seen);
        `CHK("irq raised", 1'b1, irq);
        apb(1'b0, 8'h14, 32'h0000_0000);
        `CHK("event", 32'h0000_0002, rd);
        quiet(2);
        `CHK("irq cleared", 1'b0, irq);
        cpu.fire(4'h4);
        quiet(6);
        `CHK("masked irq", 1'b0, irq);
        apb(1'b0, 8'h14, 32'h0000_0000);
        `CHK("event", 32'h0000_0008, rd);
        apb(1'b0, 8'h0C, 32'h0000_0000);
        `CHK("pending", 32'h0000_000A, rd);
        apb(1'b1, 8'h0C, 32'h0000_006F);
        apb(1'b1, 8'h00, 32'h0000_0081);
        extIrqLineA <= 1'b0;
        take(3'h0, 1'b0);
        extIrqLineA <= 1'b1;
        quiet(4);
        cpu.ret();
        quiet(8);
        `CHK("level released", 1'b0, seen);
        apb(1'b1, 8'h08, 32'h0000_0002);
        apb(1'b1, 8'h00, 32'h0000_0084);
        extIrqLineB <= 1'b0;
        take(3'h2, 1'b0);
        cpu.ret();
        quiet(8);
        `CHK("edge once", 1'b0, seen);
        extIrqLineB <= 1'b1;
        apb(1'b1, 8'h04, 32'h0000_0008);
        apb(1'b1, 8'h00, 32'h0000_009F);
        cpu.fire(4'h8);
        take(3'h1, 1'b0);
        cpu.fire(4'h8);
        quiet(3);
        cpu.fire(4'h4);
        take(3'h3, 1'b1);
        cpu.ret();
        quiet(6);
        `CHK("low waits", 1'b0, seen);
        cpu.ret();
        take(3'h1, 1'b0);
        cpu.ret();
        apb(1'b1, 8'h04, 32'h0000_0000);
        ackWait <= 4'h3;
        cpu.fire(4'h2);
        take(3'h4, 1'b0);
        apb(1'b0, 8'h0C, 32'h0000_0000);
        `CHK("tx pending", 32'h0000_0030, rd);
        apb(1'b1, 8'h0C, 32'h0000_0020);
        cpu.ret();
        cpu.fire(4'h1);
        take(3'h4, 1'b0);
        apb(1'b0, 8'h0C, 32'h0000_0000);
        `CHK("rx pending", 32'h0000_0050, rd);
        apb(1'b1, 8'h0C, 32'h0000_0040);
        cpu.ret();
        quiet(8);
        `CHK("serial cleared", 1'b0, seen);
        report_and_stop();
    end
endmodule
